// *** src/dadc_regs.svh ***
// Constants for the dual converter output control: timing, coding and host register map.
`ifndef DADC_REGS_SVH
`define DADC_REGS_SVH
`define DADC_CLK_MHZ 200
`define DADC_SCLK_MIN_MHZ 15
`define DADC_SCLK_MAX_MHZ 75
`define DADC_SCLK_MAX_PERIOD_CYC (`DADC_CLK_MHZ / `DADC_SCLK_MIN_MHZ)
`define DADC_SCLK_MIN_PERIOD_CYC ((`DADC_CLK_MHZ + `DADC_SCLK_MAX_MHZ - 1) / `DADC_SCLK_MAX_MHZ)
`define DADC_RECOVERY_US 500
`define DADC_RECOVERY_CYCLES (`DADC_RECOVERY_US * `DADC_CLK_MHZ)
`define DADC_CODE_BITS 11
`define DADC_LATENCY 4
`define DADC_SCLK_DIV 12
`define DADC_PERIOD_SAT 8'hFF
`define DADC_REG_CTRL 8'h00
`define DADC_REG_STATUS 8'h04
`define DADC_REG_DATA_A 8'h08
`define DADC_REG_DATA_B 8'h0C
`define DADC_REG_COUNT 8'h10
`define DADC_CTRL_RUN 0
`define DADC_CTRL_PD 1
`define DADC_CTRL_CODING 2
`define DADC_CTRL_REFSEL 3
`define DADC_CTRL_OE_A_N 4
`define DADC_CTRL_OE_B_N 5
`define DADC_CTRL_RESET 6'h33
`define DADC_STAT_READY 0
`define DADC_STAT_NEW_A 1
`define DADC_STAT_NEW_B 2
`endif

// *** src/dadc_pkg.sv ***
// Types shared by both ends of the dual converter link.
`include "dadc_regs.svh"
package dadc_pkg;
  typedef logic [`DADC_CODE_BITS-1:0] dadc_code_t;

  typedef enum logic [1:0] {
    ST_POWER_DOWN = 2'b00,
    ST_RECOVER = 2'b01,
    ST_RUN = 2'b10
  } dadc_mode_t;

  // Offset binary and two's complement differ only in the top bit.
  function automatic dadc_code_t dadc_apply_coding(input dadc_code_t raw, input logic twos);
    dadc_apply_coding = raw ^ {twos, {(`DADC_CODE_BITS-1){1'b0}}};
  endfunction
endpackage

// *** src/dadc_link_if.sv ***
// Pin-level link between the converter and its capture logic.
`timescale 1ns/100ps
interface dadc_link_if;
  logic sample_clk;
  logic chan_a_output_enable_n;
  logic chan_b_output_enable_n;
  logic power_down;
  logic coding_select;
  logic reference_source_select;
  dadc_pkg::dadc_code_t data_a;
  dadc_pkg::dadc_code_t data_b;
  logic data_a_oe;
  logic data_b_oe;
  dadc_pkg::dadc_code_t bus_a;
  dadc_pkg::dadc_code_t bus_b;
  logic bus_a_driven;
  logic bus_b_driven;

  // An undriven bus is seen as zero here; receivers must look at the driven flag.
  assign bus_a = data_a_oe ? data_a : '0;
  assign bus_b = data_b_oe ? data_b : '0;
  assign bus_a_driven = data_a_oe;
  assign bus_b_driven = data_b_oe;

  modport device (
    input sample_clk, chan_a_output_enable_n, chan_b_output_enable_n,
    input power_down, coding_select, reference_source_select,
    output data_a, data_b, data_a_oe, data_b_oe
  );

  modport host (
    output sample_clk, chan_a_output_enable_n, chan_b_output_enable_n,
    output power_down, coding_select, reference_source_select,
    input bus_a, bus_b, bus_a_driven, bus_b_driven
  );
endinterface

// *** src/dadc_sync3.sv ***
// Three-stage synchroniser whose output follows once stages two and three agree.
`timescale 1ns/100ps
module dadc_sync3 (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Signal
  input wire logic din,
  output logic dout
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic out_q;
  wire agree = (s2_q == s3_q);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) begin
        out_q <= s3_q;
      end
    end
  end

  assign dout = out_q;
endmodule

// *** src/dadc_device.sv ***
// Converter end: sample pipeline, coding, power-down recovery and output drive.
// Notes on behaviour
// R1: Partner supplies sample clock, 15 to 75 MHz.
// R2: Stopped or slow clock degrades accuracy; flagged.
// R3: Partner clock duty cycle near fifty percent.
// R4: Active-low enable per channel floats its bus.
// R5: Conversion continues whatever the enables show.
// R6: Power-down high holds both channels idle.
// R7: Power-down loses pipeline; outputs undefined meanwhile.
// R8: Outputs inaccurate for 500 us after release.
// R9: Coding select: low offset binary, high two's.
// R10: Coding change corrupts a few words; ignore them.
// R11: Reference select: low internal, high external pin.
// R12: Two 11-bit buses, valid with enable, power-down low.
// R13: Partner latches output words on falling edge.
// R14: Formats differ by inverting the top bit.
// R15: One word per sample clock, fixed latency.
`timescale 1ns/100ps
`include "dadc_regs.svh"
module dadc_device #(
  parameter int LATENCY = `DADC_LATENCY,
  parameter int RECOVERY_CYCLES = `DADC_RECOVERY_CYCLES,
  parameter int FORMAT_SETTLE = `DADC_LATENCY + 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Link to the capture logic
  dadc_link_if.device link,
  // Converter front end, already quantised as offset binary
  input wire dadc_pkg::dadc_code_t analog_a,
  input wire dadc_pkg::dadc_code_t analog_b,
  // Status
  output logic clock_fault,
  output logic recovering,
  output logic format_settling,
  output logic ref_external
);

  ////////////////////////////////////////////////////////////////////////////
  // Sample clock arrives from the partner and is synchronised before use.

  logic sclk_s;
  logic sclk_prev_q;
  logic [7:0] period_q;
  logic [7:0] period_d;
  logic fault_q;
  logic fault_d;

  dadc_sync3 u_sclk_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din(link.sample_clk),
    .dout(sclk_s)
  );

  wire sample_rise = sclk_s & ~sclk_prev_q;
  wire [7:0] period_now = period_q + 8'h01;
  wire too_fast = period_now < 8'(`DADC_SCLK_MIN_PERIOD_CYC);
  wire too_slow = period_now > 8'(`DADC_SCLK_MAX_PERIOD_CYC);
  wire stalled = period_q >= 8'(`DADC_SCLK_MAX_PERIOD_CYC);

  // A clock that stops leaves the stored charge decaying, so the flag rises without waiting for an edge.
  assign period_d = sample_rise ? 8'h00 : (period_q == `DADC_PERIOD_SAT) ? period_q : period_now;
  assign fault_d = sample_rise ? (too_fast | too_slow) : (fault_q | stalled); // R2

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_prev_q <= 1'b0;
      period_q <= `DADC_PERIOD_SAT;
      fault_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      period_q <= period_d;
      fault_q <= fault_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power mode: idle while power-down is high, then a recovery wait.

  dadc_pkg::dadc_mode_t mode_q;
  dadc_pkg::dadc_mode_t mode_d;
  logic [31:0] rec_q;
  logic [31:0] rec_d;

  wire rec_done = rec_q == 32'(RECOVERY_CYCLES - 1);

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      dadc_pkg::ST_POWER_DOWN: begin
        if (!link.power_down) begin
          mode_d = dadc_pkg::ST_RECOVER; // R6
        end
      end
      dadc_pkg::ST_RECOVER: begin
        if (link.power_down) begin
          mode_d = dadc_pkg::ST_POWER_DOWN;
        end else if (rec_done) begin
          mode_d = dadc_pkg::ST_RUN; // R8
        end
      end
      dadc_pkg::ST_RUN: begin
        if (link.power_down) begin
          mode_d = dadc_pkg::ST_POWER_DOWN; // R6
        end
      end
      default: begin
        mode_d = dadc_pkg::ST_POWER_DOWN;
      end
    endcase
  end

  assign rec_d = (mode_q == dadc_pkg::ST_RECOVER && !rec_done) ? rec_q + 32'h1 : 32'h0; // R8

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= dadc_pkg::ST_POWER_DOWN;
      rec_q <= 32'h0;
    end else begin
      mode_q <= mode_d;
      rec_q <= rec_d;
    end
  end

  wire powered = mode_q != dadc_pkg::ST_POWER_DOWN;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion pipeline. Coding is applied on entry, so a coding change
  // reaches the pins only after the pipeline has flushed.

  dadc_pkg::dadc_code_t pipe_a_q [0:LATENCY-1];
  dadc_pkg::dadc_code_t pipe_b_q [0:LATENCY-1];

  wire dadc_pkg::dadc_code_t coded_a = dadc_pkg::dadc_apply_coding(analog_a, link.coding_select); // R9 R14
  wire dadc_pkg::dadc_code_t coded_b = dadc_pkg::dadc_apply_coding(analog_b, link.coding_select); // R9 R14

  // The enables take no part here: conversion runs on whether or not the pins drive.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe_a_q[i] <= '0;
        pipe_b_q[i] <= '0;
      end
    end else if (!powered) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe_a_q[i] <= '0; // R7
        pipe_b_q[i] <= '0; // R7
      end
    end else if (sample_rise) begin
      pipe_a_q[0] <= coded_a; // R5 R15
      pipe_b_q[0] <= coded_b; // R5 R15
      for (int i = 1; i < LATENCY; i++) begin
        pipe_a_q[i] <= pipe_a_q[i-1]; // R15
        pipe_b_q[i] <= pipe_b_q[i-1]; // R15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Coding change watch: words already in flight carry the old coding.

  logic coding_prev_q;
  logic [7:0] settle_q;
  logic [7:0] settle_d;

  wire coding_changed = link.coding_select != coding_prev_q;

  assign settle_d = coding_changed ? 8'(FORMAT_SETTLE) :
                    (sample_rise && settle_q != 8'h00) ? settle_q - 8'h01 : settle_q; // R10

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      coding_prev_q <= 1'b0;
      settle_q <= 8'h00;
    end else begin
      coding_prev_q <= link.coding_select;
      settle_q <= settle_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference source. The analog scaling lives outside this block; only the
  // selection is tracked so the front end model can follow it.

  logic ref_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= link.reference_source_select; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and status.

  assign link.data_a = pipe_a_q[LATENCY-1]; // R12 R15
  assign link.data_b = pipe_b_q[LATENCY-1]; // R12 R15
  assign link.data_a_oe = ~link.chan_a_output_enable_n; // R4
  assign link.data_b_oe = ~link.chan_b_output_enable_n; // R4

  assign clock_fault = fault_q; // R2
  assign recovering = mode_q == dadc_pkg::ST_RECOVER; // R8
  assign format_settling = settle_q != 8'h00; // R10
  assign ref_external = ref_q; // R11

endmodule

// *** src/dadc_host.sv ***
// Capture end: makes the sample clock, drives the control pins and keeps only trustworthy words.
`timescale 1ns/100ps
`include "dadc_regs.svh"
module dadc_host #(
  parameter int DIV = `DADC_SCLK_DIV,
  parameter int RECOVERY_CYCLES = `DADC_RECOVERY_CYCLES,
  parameter int FORMAT_SETTLE = `DADC_LATENCY + 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Link to the converter
  dadc_link_if.host link,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Accepted samples
  output dadc_pkg::dadc_code_t sample_a,
  output dadc_pkg::dadc_code_t sample_b,
  output logic sample_a_valid,
  output logic sample_b_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // Divider held inside the legal sample clock band.

  localparam int DIV_LO = `DADC_SCLK_MIN_PERIOD_CYC;
  localparam int DIV_HI = `DADC_SCLK_MAX_PERIOD_CYC;
  localparam int DIV_USED = (DIV < DIV_LO) ? DIV_LO : (DIV > DIV_HI) ? DIV_HI : DIV; // R1
  localparam int HALF = DIV_USED / 2;

  logic [5:0] ctrl_q;
  logic [7:0] div_q;
  logic [7:0] div_d;
  logic sclk_q;

  wire run = ctrl_q[`DADC_CTRL_RUN];
  wire div_wrap = div_q == 8'(DIV_USED - 1);
  assign div_d = (!run || div_wrap) ? 8'h00 : div_q + 8'h01; // R1
  // Odd dividers cannot give an exact half; the high phase is the shorter one.
  wire sclk_d = run & (div_d < 8'(HALF)); // R3
  // The converter updates its pins a few cycles after the rise, so words are taken at the fall.
  wire capture = run & (div_q == 8'(HALF)); // R13

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // Starting on the last count makes the first high phase after reset a full one.
      div_q <= 8'(DIV_USED - 1); // R3
      sclk_q <= 1'b0;
    end else begin
      div_q <= div_d;
      sclk_q <= sclk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Discard windows after power-down release and after a coding change.

  logic [31:0] rec_q;
  logic [31:0] rec_d;
  logic [7:0] fmt_q;
  logic [7:0] fmt_d;
  logic coding_prev_q;

  wire pd = ctrl_q[`DADC_CTRL_PD];
  wire coding = ctrl_q[`DADC_CTRL_CODING];
  assign rec_d = pd ? 32'(RECOVERY_CYCLES) : (rec_q != 32'h0) ? rec_q - 32'h1 : rec_q; // R8
  assign fmt_d = (coding != coding_prev_q) ? 8'(FORMAT_SETTLE) :
                 (capture && fmt_q != 8'h00) ? fmt_q - 8'h01 : fmt_q; // R10
  wire ready = !pd && rec_q == 32'h0 && fmt_q == 8'h00;
  wire accept_a = capture & ready & link.bus_a_driven;
  wire accept_b = capture & ready & link.bus_b_driven;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rec_q <= 32'(RECOVERY_CYCLES);
      fmt_q <= 8'h00;
      coding_prev_q <= 1'b0;
    end else begin
      rec_q <= rec_d;
      fmt_q <= fmt_d;
      coding_prev_q <= coding;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers. A new sample wins over the clear by a read in the same cycle.

  dadc_pkg::dadc_code_t sa_q;
  dadc_pkg::dadc_code_t sb_q;
  logic va_q;
  logic vb_q;
  logic new_a_q;
  logic new_b_q;
  logic [15:0] count_q;
  logic [31:0] rdata_q;

  wire sel_ctrl = reg_addr == `DADC_REG_CTRL;
  wire sel_status = reg_addr == `DADC_REG_STATUS;
  wire sel_a = reg_addr == `DADC_REG_DATA_A;
  wire sel_b = reg_addr == `DADC_REG_DATA_B;
  wire sel_count = reg_addr == `DADC_REG_COUNT;
  wire new_a_d = accept_a | (new_a_q & ~(reg_rd & sel_a));
  wire new_b_d = accept_b | (new_b_q & ~(reg_rd & sel_b));
  wire [31:0] status_w = 32'({new_b_q, new_a_q, ready});
  wire [31:0] rd_mux = sel_ctrl ? 32'(ctrl_q) : sel_status ? status_w : sel_a ? 32'(sa_q) :
                       sel_b ? 32'(sb_q) : sel_count ? 32'(count_q) : 32'h0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `DADC_CTRL_RESET;
      sa_q <= '0;
      sb_q <= '0;
      va_q <= 1'b0;
      vb_q <= 1'b0;
      new_a_q <= 1'b0;
      new_b_q <= 1'b0;
      count_q <= 16'h0000;
      rdata_q <= 32'h0;
    end else begin
      if (reg_wr && sel_ctrl) begin
        ctrl_q <= reg_wdata[5:0];
      end
      if (accept_a) begin
        sa_q <= link.bus_a;
      end
      if (accept_b) begin
        sb_q <= link.bus_b;
      end
      va_q <= accept_a;
      vb_q <= accept_b;
      new_a_q <= new_a_d;
      new_b_q <= new_b_d;
      if (accept_a || accept_b) begin
        count_q <= count_q + 16'h0001;
      end
      rdata_q <= reg_rd ? rd_mux : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and outputs.

  assign link.sample_clk = sclk_q;
  assign link.power_down = pd;
  assign link.coding_select = coding;
  assign link.reference_source_select = ctrl_q[`DADC_CTRL_REFSEL];
  assign link.chan_a_output_enable_n = ctrl_q[`DADC_CTRL_OE_A_N];
  assign link.chan_b_output_enable_n = ctrl_q[`DADC_CTRL_OE_B_N];
  assign reg_rdata = rdata_q;
  assign sample_a = sa_q;
  assign sample_b = sb_q;
  assign sample_a_valid = va_q;
  assign sample_b_valid = vb_q;

endmodule

// *** sim/dadc_sva.sv ***
// Concurrent checks on the signals of the converter link.
`timescale 1ns/100ps
module dadc_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Link signals
  input wire logic sample_clk,
  input wire logic chan_a_output_enable_n,
  input wire logic chan_b_output_enable_n,
  input wire logic power_down,
  input wire logic coding_select,
  input wire logic data_a_oe,
  input wire logic data_b_oe,
  input wire dadc_pkg::dadc_code_t data_a,
  input wire dadc_pkg::dadc_code_t data_b,
  input wire dadc_pkg::dadc_code_t bus_a
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  property p_oe_a;
    data_a_oe == !chan_a_output_enable_n;
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("Channel A drive does not follow its enable.");
  property p_oe_b;
    data_b_oe == !chan_b_output_enable_n;
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("Channel B drive does not follow its enable.");
  property p_bus_idle;
    !data_a_oe |-> bus_a == '0;
  endproperty
  a_bus_idle: assert property (p_bus_idle) else $error("Undriven bus A shows data.");
  // Eight cycles leave room for the mode register and the pipeline clear inside the converter.
  property p_pd_a;
    power_down [*8] |-> data_a == '0;
  endproperty
  a_pd_a: assert property (p_pd_a) else $error("Channel A output not cleared in power-down.");
  property p_pd_b;
    power_down [*8] |-> data_b == '0;
  endproperty
  a_pd_b: assert property (p_pd_b) else $error("Channel B output not cleared in power-down.");
  // A word may only change shortly after a sample clock rise, never in the low phase.
  property p_upd_a;
    $changed(data_a) && !power_down && !$past(power_down) |-> $past(sample_clk, 3) && $past(sample_clk, 4);
  endproperty
  a_upd_a: assert property (p_upd_a) else $error("Channel A word changed away from a sample clock rise.");
  property p_upd_b;
    $changed(data_b) && !power_down && !$past(power_down) |-> $past(sample_clk, 3) && $past(sample_clk, 4);
  endproperty
  a_upd_b: assert property (p_upd_b) else $error("Channel B word changed away from a sample clock rise.");
  property p_hi;
    $rose(sample_clk) |-> sample_clk [*6] ##1 !sample_clk;
  endproperty
  a_hi: assert property (p_hi) else $error("Sample clock high phase is not six cycles.");
  property p_lo;
    $fell(sample_clk) |-> (!sample_clk) [*6] ##1 sample_clk;
  endproperty
  a_lo: assert property (p_lo) else $error("Sample clock low phase is not six cycles.");
  c_pd: cover property (power_down [*8]);
  c_oe_off: cover property ($rose(sample_clk) && chan_a_output_enable_n);
  c_coding: cover property ($changed(coding_select) && !power_down);
endmodule

// *** sim/tb_dual_adc_output_control.sv ***
// Testbench joining both ends of the converter link and checking the accepted samples.
`timescale 1ns/100ps
`include "dadc_regs.svh"
module tb_dual_adc_output_control;
  // A short recovery keeps the run brief; both ends get the same value.
  localparam int RECOV = 20;
  typedef struct packed {
    logic coding;
    logic refsel;
    dadc_pkg::dadc_code_t in_a;
    dadc_pkg::dadc_code_t in_b;
    dadc_pkg::dadc_code_t exp_a;
    dadc_pkg::dadc_code_t exp_b;
  } dadc_row_t;
  logic clk;
  logic arst_n;
  dadc_pkg::dadc_code_t analog_a;
  dadc_pkg::dadc_code_t analog_b;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  dadc_pkg::dadc_code_t sample_a;
  dadc_pkg::dadc_code_t sample_b;
  logic sample_a_valid;
  logic sample_b_valid;
  logic clock_fault;
  logic recovering;
  logic format_settling;
  logic ref_external;
  int err_count;
  int n_compared;
  int cyc;
  logic [31:0] rd;
  dadc_row_t rows [4];
  dadc_link_if link ();
  dadc_device #(.RECOVERY_CYCLES(RECOV)) i_dadc_device (.clk(clk), .arst_n(arst_n), .link(link),
    .analog_a(analog_a), .analog_b(analog_b), .clock_fault(clock_fault), .recovering(recovering),
    .format_settling(format_settling), .ref_external(ref_external));
  dadc_host #(.RECOVERY_CYCLES(RECOV)) i_dadc_host (.clk(clk), .arst_n(arst_n), .link(link),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_a(sample_a), .sample_b(sample_b), .sample_a_valid(sample_a_valid), .sample_b_valid(sample_b_valid));
  dadc_sva i_dadc_sva (.clk(clk), .arst_n(arst_n), .sample_clk(link.sample_clk),
    .chan_a_output_enable_n(link.chan_a_output_enable_n), .chan_b_output_enable_n(link.chan_b_output_enable_n),
    .power_down(link.power_down), .coding_select(link.coding_select), .data_a_oe(link.data_a_oe),
    .data_b_oe(link.data_b_oe), .data_a(link.data_a), .data_b(link.data_b), .bus_a(link.bus_a));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check_code(input string what, input dadc_pkg::dadc_code_t exp, input dadc_pkg::dadc_code_t got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  function automatic logic [31:0] ctrl(input logic pd, input logic cod, input logic rs, input logic na, input logic nb);
    ctrl = {26'h0, nb, na, rs, cod, pd, 1'b1};
  endfunction
  // Waits for an accepted word on one channel; the bound turns a hang into a reported failure.
  task automatic wait_valid(input logic ch, output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while ((ch ? sample_b_valid : sample_a_valid) !== 1'b1 && c < 2000);
    if (c >= 2000) begin
      err_count++;
      $display("Error sample valid expected 1 seen timeout");
      results();
    end
  endtask
  task automatic power_up();
    reg_write(`DADC_REG_CTRL, ctrl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    repeat (6) @(posedge clk);
    #1;
    check_bit("recovering", 1'b1, recovering);
    wait_valid(1'b0, cyc);
    check_bit("recovery gap", 1'b1, cyc + 6 > RECOV);
    check_bit("recovered", 1'b0, recovering);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    arst_n = 1'b0;
    analog_a = '0;
    analog_b = '0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    err_count = 0;
    n_compared = 0;
    rows[0] = '{1'b0, 1'b0, 11'h400, 11'h000, 11'h400, 11'h000};
    rows[1] = '{1'b1, 1'b1, 11'h400, 11'h000, 11'h000, 11'h400};
    rows[2] = '{1'b1, 1'b0, 11'h7FF, 11'h200, 11'h3FF, 11'h600};
    rows[3] = '{1'b0, 1'b1, 11'h7FF, 11'h200, 11'h7FF, 11'h200};
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    reg_read(`DADC_REG_CTRL, rd);
    check_word("ctrl reset", 32'h33, rd);
    check_bit("data_a_oe reset", 1'b0, link.data_a_oe);
    power_up();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      analog_a <= rows[i].in_a;
      analog_b <= rows[i].in_b;
      reg_write(`DADC_REG_CTRL, ctrl(1'b0, rows[i].coding, rows[i].refsel, 1'b0, 1'b0));
      if (i > 0 && rows[i].coding !== rows[i - 1].coding) begin
        @(posedge clk);
        #1;
        check_bit("format_settling", 1'b1, format_settling);
      end
      wait_valid(1'b0, cyc);
      if (i > 0 && rows[i].coding !== rows[i - 1].coding) begin
        check_bit("settle gap", 1'b1, cyc >= 48);
      end
      for (int k = 0; k < 5; k++) begin
        wait_valid(1'b0, cyc);
      end
      check_code("sample_a", rows[i].exp_a, sample_a);
      check_code("sample_b", rows[i].exp_b, sample_b);
      check_code("bus_a", rows[i].exp_a, link.bus_a);
      check_bit("ref_external", rows[i].refsel, ref_external);
      check_bit("clock_fault", 1'b0, clock_fault);
      check_bit("format_settled", 1'b0, format_settling);
      reg_read(`DADC_REG_DATA_A, rd);
      check_word("data_a reg", {21'h0, rows[i].exp_a}, rd);
      $display("Row %0d done", i);
    end
    // Channel A disabled: its pipeline must keep running although none of its words are accepted; channel B is still accepted.
    reg_write(`DADC_REG_CTRL, ctrl(1'b0, 1'b0, 1'b0, 1'b1, 1'b0));
    @(posedge clk);
    analog_a <= 11'h155;
    for (int k = 0; k < 6; k++) begin
      wait_valid(1'b1, cyc);
    end
    check_bit("bus_a_driven", 1'b0, link.bus_a_driven);
    check_code("data_a pins", 11'h155, link.data_a);
    check_code("sample_a held", 11'h7FF, sample_a);
    reg_write(`DADC_REG_CTRL, ctrl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    wait_valid(1'b0, cyc);
    check_code("sample_a enabled", 11'h155, sample_a);
    reg_read(`DADC_REG_STATUS, rd);
    check_bit("status ready", 1'b1, rd[`DADC_STAT_READY]);
    $display("Enable test done");
    reg_write(`DADC_REG_CTRL, ctrl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
    repeat (12) @(posedge clk);
    #1;
    check_code("data_a in power-down", 11'h000, link.data_a);
    cyc = 0;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (sample_a_valid === 1'b1) begin
        cyc++;
      end
    end
    check_bit("no capture in power-down", 1'b1, cyc == 0);
    reg_read(`DADC_REG_STATUS, rd);
    check_bit("status ready in power-down", 1'b0, rd[`DADC_STAT_READY]);
    power_up();
    $display("Power-down test done");
    reg_write(8'h20, 32'h0000_0000);
    reg_read(8'h20, rd);
    check_word("unmapped read", 32'h0, rd);
    reg_read(`DADC_REG_CTRL, rd);
    check_word("ctrl after unmapped write", 32'h1, rd);
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    #1;
    check_code("data_a in reset", 11'h000, link.data_a);
    check_bit("sample_clk in reset", 1'b0, link.sample_clk);
    check_bit("clock_fault in reset", 1'b1, clock_fault);
    @(posedge clk);
    arst_n <= 1'b1;
    reg_read(`DADC_REG_CTRL, rd);
    check_word("ctrl after reset", 32'h33, rd);
    reg_read(`DADC_REG_COUNT, rd);
    check_word("count after reset", 32'h0, rd);
    $display("Register and reset test done");
    results();
  end
endmodule
